// >>> verilog/aocr_regs.sv
`timescale 1ns/1ps
`include "aocr_map.svh"
// Notes on behaviour
// [R1] With per-line pattern enable high, line 3 carries the pattern coded in bits 7-5.
// [R2] With per-line pattern enable high, line 4 carries the pattern coded in bits 4-2.
// [R3] Codes 0-7 mean normal, sync halves, alternating, custom, ones, toggle, zeros, ramp.
// [R4] Bits 15-12 put the digital block of channel 4 down to 1 to sleep when set.
// [R5] Bits 11-8 put serial line 4 down to 1 to sleep when set.
// [R6] Bits 7-4 put the analog chain of channel 4 down to 1 to sleep when set.
// [R7] Bits 3-0 invert the data sent on line 4 down to 1 when set.
// [R8] Inversion touches normal data only, never a test pattern.
// [R9] With global gain on, channel 5 is scaled by N times 0.2 dB, N from bits 15-11.
// [R10] With global offset on, channel 5 gets the signed 10-bit offset of bits 9-0 added.
// [R11] Software writes the same channel 5 offset into both offset registers.
// [R12] Software writes zero to every reserved bit.
module aocr_regs #(
   parameter int               W           = 14,
   parameter logic [W-1:0]     CUSTOM_WORD = '0
) (
   input  wire logic              REF_CLK,
   input  wire logic              NRST,
   input  wire logic [7:0]        ADDR,
   input  wire logic [15:0]       WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output      logic [15:0]       RDATA,
   input  wire logic              PER_LINE_PATTERN_ENABLE,
   input  wire logic              GLOBAL_GAIN_APPLY,
   input  wire logic              GLOBAL_OFFSET_APPLY,
   output      logic [3:0]        DIGITAL_SLEEP,
   output      logic [3:0]        LINE_SLEEP,
   output      logic [3:0]        ANALOG_SLEEP,
   input  wire logic [4*W-1:0]    LINE_DATA_IN,
   input  wire logic              LINE_VALID_IN,
   output      logic [4*W-1:0]    LINE_DATA_OUT,
   output      logic              LINE_VALID_OUT,
   input  wire logic [W-1:0]      CH5_DATA_IN,
   input  wire logic              CH5_VALID_IN,
   output      logic [W-1:0]      CH5_DATA_OUT,
   output      logic              CH5_VALID_OUT,
   output      logic              OFFSET_MISMATCH
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic                  rst_meta_r;
   logic                  rst_n;
   aocr_pkg::aocr_word_t  pat_r;
   aocr_pkg::aocr_word_t  pwr_r;
   aocr_pkg::aocr_word_t  gof_r;
   aocr_pkg::aocr_word_t  ofc_r;
   logic [15:0]           rdata_r;
   logic [W-1:0]          line_out_r [4];
   logic                  line_vld_r;
   logic signed [W-1:0]   s1_r;
   logic                  s1_vld_r;
   logic signed [W-1:0]   ch5_r;
   logic                  ch5_vld_r;
   logic                  mism_r;

   // two-stage release of the asynchronous reset
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   // writes, full 16-bit words stored as written
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pat_r <= `AOCR_REG_RESET;
         pwr_r <= `AOCR_REG_RESET;
         gof_r <= `AOCR_REG_RESET;
         ofc_r <= `AOCR_REG_RESET;
      end else if (WR) begin
         case (ADDR)
            `AOCR_PAT_SEL_OFS:  pat_r <= WDATA;
            `AOCR_PWR_INV_OFS:  pwr_r <= WDATA;
            `AOCR_GAIN_OFS_OFS: gof_r <= WDATA;
            `AOCR_OFS_COPY_OFS: ofc_r <= WDATA;
            default:            ;
         endcase
      end
   end

   // read data for one cycle after the strobe, zero otherwise
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 16'h0000;
      end else if (RD) begin
         case (ADDR)
            `AOCR_PAT_SEL_OFS:  rdata_r <= pat_r;
            `AOCR_PWR_INV_OFS:  rdata_r <= pwr_r;
            `AOCR_GAIN_OFS_OFS: rdata_r <= gof_r;
            `AOCR_OFS_COPY_OFS: rdata_r <= ofc_r;
            default:            rdata_r <= 16'h0000;
         endcase
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   // copies of the channel 5 offset disagree
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         mism_r <= 1'b0;
      end else begin
         mism_r <= gof_r[`AOCR_OFFSET_HI:`AOCR_OFFSET_LO] !=
                   ofc_r[`AOCR_OFFSET_HI:`AOCR_OFFSET_LO];
      end
   end

   assign RDATA           = rdata_r;
   assign OFFSET_MISMATCH = mism_r;
   assign DIGITAL_SLEEP   = pwr_r[`AOCR_DIG_SLEEP_LO +: 4];   // [R4]
   assign LINE_SLEEP      = pwr_r[`AOCR_LINE_SLEEP_LO +: 4];  // [R5]
   assign ANALOG_SLEEP    = pwr_r[`AOCR_ANA_SLEEP_LO +: 4];   // [R6]

   // ----------------------------------------------------------------
   // serial output lines 1 to 4
   // ----------------------------------------------------------------
   localparam logic [W-1:0] SYNC_WORD = {{(W/2){1'b1}}, {(W-W/2){1'b0}}};
   localparam logic [W-1:0] ALT_WORD  = {(W/2){2'b10}};

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_line
         localparam int HI = (i == 2) ? `AOCR_LINE3_PAT_HI : `AOCR_LINE4_PAT_HI;
         logic [W-1:0]        ramp_r;
         logic                tog_r;
         aocr_pkg::aocr_pat_t code;
         logic [W-1:0]        word;

         // only lines 3 and 4 take a code from this bank
         assign code = (i >= 2 && PER_LINE_PATTERN_ENABLE) ?
                       aocr_pkg::aocr_pat_t'(pat_r[HI -: 3]) :
                       aocr_pkg::AOCR_PAT_NORMAL;               // [R1] [R2]

         // pattern decode; inversion only on normal data
         always_comb begin
            unique case (code)                                  // [R3]
               aocr_pkg::AOCR_PAT_NORMAL:
                  word = pwr_r[`AOCR_FLIP_LO + i] ?
                         ~LINE_DATA_IN[i*W +: W] : LINE_DATA_IN[i*W +: W]; // [R7] [R8]
               aocr_pkg::AOCR_PAT_SYNC:   word = SYNC_WORD;
               aocr_pkg::AOCR_PAT_ALT:    word = ALT_WORD;
               aocr_pkg::AOCR_PAT_CUSTOM: word = CUSTOM_WORD;
               aocr_pkg::AOCR_PAT_ONES:   word = '1;
               aocr_pkg::AOCR_PAT_TOGGLE: word = tog_r ? ~ALT_WORD : ALT_WORD;
               aocr_pkg::AOCR_PAT_ZEROS:  word = '0;
               aocr_pkg::AOCR_PAT_RAMP:   word = ramp_r;
            endcase
         end

         // ramp and toggle advance per sample while selected
         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               ramp_r <= '0;
               tog_r  <= 1'b0;
            end else if (LINE_VALID_IN) begin
               ramp_r <= (code == aocr_pkg::AOCR_PAT_RAMP) ? ramp_r + 1'b1 : '0;
               tog_r  <= (code == aocr_pkg::AOCR_PAT_TOGGLE) ? ~tog_r : 1'b0;
            end
         end

         // sleeping line sends zeros
         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               line_out_r[i] <= '0;
            end else if (LINE_VALID_IN) begin
               line_out_r[i] <= pwr_r[`AOCR_LINE_SLEEP_LO + i] ? '0 : word; // [R5]
            end
         end
      end
   endgenerate

   // sample strobe follows the data
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         line_vld_r <= 1'b0;
      end else begin
         line_vld_r <= LINE_VALID_IN;
      end
   end

   assign LINE_DATA_OUT  = {line_out_r[3], line_out_r[2], line_out_r[1], line_out_r[0]};
   assign LINE_VALID_OUT = line_vld_r;

   // ----------------------------------------------------------------
   // channel 5 offset then gain
   // ----------------------------------------------------------------
   function automatic logic signed [W-1:0] sat(input logic signed [W+5:0] v);
      logic signed [W+5:0] mx;
      logic signed [W+5:0] mn;
      mx = {{7{1'b0}}, {(W-1){1'b1}}};
      mn = {{7{1'b1}}, {(W-1){1'b0}}};
      if (v > mx) return mx[W-1:0];
      if (v < mn) return mn[W-1:0];
      return v[W-1:0];
   endfunction

   // gain table, 10^(N/100) with 12 fraction bits
   function automatic logic [15:0] gain_coef(input logic [4:0] n);
      logic [15:0] c;
      c = 16'h1000;
      case (n)
         5'h01: c = 16'h105f;  5'h02: c = 16'h10c1;  5'h03: c = 16'h1125;
         5'h04: c = 16'h118b;  5'h05: c = 16'h11f4;  5'h06: c = 16'h125f;
         5'h07: c = 16'h12cc;  5'h08: c = 16'h133c;  5'h09: c = 16'h13af;
         5'h0a: c = 16'h1425;  5'h0b: c = 16'h149d;  5'h0c: c = 16'h1518;
         5'h0d: c = 16'h1595;  5'h0e: c = 16'h1616;  5'h0f: c = 16'h169a;
         5'h10: c = 16'h1721;  5'h11: c = 16'h17aa;  5'h12: c = 16'h1838;
         5'h13: c = 16'h18c8;  5'h14: c = 16'h195c;  5'h15: c = 16'h19f3;
         5'h16: c = 16'h1a8e;  5'h17: c = 16'h1b2c;  5'h18: c = 16'h1bce;
         5'h19: c = 16'h1c74;  5'h1a: c = 16'h1d1e;  5'h1b: c = 16'h1dcb;
         5'h1c: c = 16'h1e7d;  5'h1d: c = 16'h1f33;  5'h1e: c = 16'h1fed;
         5'h1f: c = 16'h20ab;
         default: c = 16'h1000;
      endcase
      return c;
   endfunction

   logic signed [W+5:0]  in_ext;
   logic signed [W+5:0]  off_ext;
   logic signed [W+22:0] prod;
   logic signed [W+22:0] prod_sh;

   assign in_ext  = {{6{CH5_DATA_IN[W-1]}}, CH5_DATA_IN};
   assign off_ext = {{(W-4){gof_r[`AOCR_OFFSET_HI]}}, gof_r[`AOCR_OFFSET_HI:`AOCR_OFFSET_LO]};
   assign prod    = $signed({{6{s1_r[W-1]}}, s1_r}) *
                    $signed({1'b0, gain_coef(gof_r[`AOCR_GAIN_HI:`AOCR_GAIN_LO])});
   assign prod_sh = prod >>> `AOCR_GAIN_FRAC;

   // stage 1: saturating offset add
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s1_r     <= '0;
         s1_vld_r <= 1'b0;
      end else begin
         s1_vld_r <= CH5_VALID_IN;
         if (CH5_VALID_IN) begin
            s1_r <= GLOBAL_OFFSET_APPLY ? sat(in_ext + off_ext) : CH5_DATA_IN; // [R10]
         end
      end
   end

   // stage 2: saturating gain
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ch5_r     <= '0;
         ch5_vld_r <= 1'b0;
      end else begin
         ch5_vld_r <= s1_vld_r;
         if (s1_vld_r) begin
            ch5_r <= GLOBAL_GAIN_APPLY ? sat(prod_sh[W+5:0]) : s1_r;          // [R9]
         end
      end
   end

   assign CH5_DATA_OUT  = ch5_r;
   assign CH5_VALID_OUT = ch5_vld_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_line3_ones: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R1]
      LINE_VALID_IN && PER_LINE_PATTERN_ENABLE && pat_r[7:5] == 3'h4 && !pwr_r[10]
      |=> line_out_r[2] == '1) else $error("line 3 not all ones");
   a_line4_zeros: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R2]
      LINE_VALID_IN && PER_LINE_PATTERN_ENABLE && pat_r[4:2] == 3'h6
      |=> line_out_r[3] == '0) else $error("line 4 not all zeros");
   a_pattern_sync: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R3]
      LINE_VALID_IN && PER_LINE_PATTERN_ENABLE && pat_r[7:5] == 3'h1 && !pwr_r[10]
      |=> line_out_r[2] == SYNC_WORD) else $error("line 3 sync word wrong");
   a_dig_sleep_wr: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R4]
      WR && ADDR == `AOCR_PWR_INV_OFS |=> DIGITAL_SLEEP == $past(WDATA[15:12]))
      else $error("digital sleep not updated");
   a_line_sleep_out: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R5]
      LINE_VALID_IN && pwr_r[8] |=> line_out_r[0] == '0)
      else $error("sleeping line 1 not quiet");
   a_ana_sleep_wr: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R6]
      WR && ADDR == `AOCR_PWR_INV_OFS |=> ANALOG_SLEEP == $past(WDATA[7:4]))
      else $error("analog sleep not updated");
   a_line1_invert: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R7]
      LINE_VALID_IN && pwr_r[0] && !pwr_r[8]
      |=> line_out_r[0] == ~$past(LINE_DATA_IN[W-1:0])) else $error("line 1 not inverted");
   a_pattern_noinv: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R8]
      LINE_VALID_IN && PER_LINE_PATTERN_ENABLE && pat_r[4:2] == 3'h4 && pwr_r[3] && !pwr_r[11]
      |=> line_out_r[3] == '1) else $error("pattern altered by inversion");
   a_gain_bypass: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R9]
      s1_vld_r && (!GLOBAL_GAIN_APPLY || gof_r[15:11] == 5'h00)
      |=> ch5_vld_r && ch5_r == $past(s1_r)) else $error("unity gain changed data");
   a_offset_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n) // [R10]
      CH5_VALID_IN && (!GLOBAL_OFFSET_APPLY || gof_r[9:0] == 10'h000)
      |=> s1_r == $past(CH5_DATA_IN)) else $error("zero offset changed data");

endmodule // aocr_regs

// >>> common/aocr_map.svh
`ifndef AOCR_MAP_SVH
`define AOCR_MAP_SVH

// ----------------------------------------------------------------
// register offsets (plain register port, 8-bit address)
// ----------------------------------------------------------------
`define AOCR_PAT_SEL_OFS    8'h17
`define AOCR_PWR_INV_OFS    8'h18
`define AOCR_GAIN_OFS_OFS   8'h19
`define AOCR_OFS_COPY_OFS   8'h1a

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define AOCR_REG_RESET      16'h0000
`define AOCR_LINE3_PAT_HI   7
`define AOCR_LINE4_PAT_HI   4
`define AOCR_DIG_SLEEP_LO   12
`define AOCR_LINE_SLEEP_LO  8
`define AOCR_ANA_SLEEP_LO   4
`define AOCR_FLIP_LO        0
`define AOCR_GAIN_HI        15
`define AOCR_GAIN_LO        11
`define AOCR_OFFSET_HI      9
`define AOCR_OFFSET_LO      0
`define AOCR_GAIN_FRAC      12

`endif

// >>> common/aocr_pkg.sv
package aocr_pkg;

   // ----------------------------------------------------------------
   // pattern-select codes for the serial output lines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      AOCR_PAT_NORMAL = 3'h0,
      AOCR_PAT_SYNC   = 3'h1,
      AOCR_PAT_ALT    = 3'h2,
      AOCR_PAT_CUSTOM = 3'h3,
      AOCR_PAT_ONES   = 3'h4,
      AOCR_PAT_TOGGLE = 3'h5,
      AOCR_PAT_ZEROS  = 3'h6,
      AOCR_PAT_RAMP   = 3'h7
   } aocr_pat_t;

   typedef logic [15:0] aocr_word_t;

endpackage

// >>> tb/adc_output_ctrl_regs_tb_top.sv
`timescale 1ns/1ps
`include "aocr_map.svh"
module adc_output_ctrl_regs_tb_top;

   // ----------------------------------------------------------------
   // stimulus rows and bench signals
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [15:0] rexp;
   } aocr_tb_row_t;

   localparam aocr_tb_row_t ROWS [5] = '{ // reserved bits of the bank written as zero
      '{8'h17, 16'h00fc, 16'h00fc}, '{8'h18, 16'ha5c3, 16'ha5c3},
      '{8'h19, 16'hf803, 16'hf803}, '{8'h1a, 16'h03ff, 16'h03ff},
      '{8'h20, 16'hffff, 16'h0000}};
   // line 3 pattern per code, first and second sample (line 3 flip set)
   localparam logic [13:0] PAT1 [8] = '{14'h2dcb, 14'h3f80, 14'h2aaa, 14'h0000,
                                       14'h3fff, 14'h2aaa, 14'h0000, 14'h0000};
   localparam logic [13:0] PAT2 [8] = '{14'h2dcb, 14'h3f80, 14'h2aaa, 14'h0000,
                                       14'h3fff, 14'h1555, 14'h0000, 14'h0001};

   logic        ref_clk, nrst, wr, rd, pat_en, gain_en, ofs_en, lv_in, c5_vin;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, rv;
   logic [3:0]  dig_sl, line_sl, ana_sl;
   logic [55:0] ld_in, ld_out;
   logic [13:0] c5_in, c5_out;
   logic        lv_out, c5_vout, ofs_mis;
   int          errors, cmp_count;

   aocr_regs dut (
      .REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .PER_LINE_PATTERN_ENABLE(pat_en), .GLOBAL_GAIN_APPLY(gain_en),
      .GLOBAL_OFFSET_APPLY(ofs_en), .DIGITAL_SLEEP(dig_sl), .LINE_SLEEP(line_sl),
      .ANALOG_SLEEP(ana_sl), .LINE_DATA_IN(ld_in), .LINE_VALID_IN(lv_in),
      .LINE_DATA_OUT(ld_out), .LINE_VALID_OUT(lv_out), .CH5_DATA_IN(c5_in),
      .CH5_VALID_IN(c5_vin), .CH5_DATA_OUT(c5_out), .CH5_VALID_OUT(c5_vout),
      .OFFSET_MISMATCH(ofs_mis));

   // ----------------------------------------------------------------
   // clock, shared tasks and closing
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // one sample on all four lines, output checked on line 3
   task automatic line_smp(input logic [13:0] exp3);
      @(posedge ref_clk);
      lv_in <= 1'b1;
      @(posedge ref_clk);
      lv_in <= 1'b0;
      #1 chk(ld_out[41:28], exp3);
      chk(lv_out, 1'b1);
   endtask

   task automatic ch5_smp(input logic [13:0] din, input logic [13:0] exp);
      @(posedge ref_clk);
      c5_in  <= din;
      c5_vin <= 1'b1;
      @(posedge ref_clk);
      c5_vin <= 1'b0;
      @(posedge ref_clk);
      #1 chk(c5_out, exp);
      chk(c5_vout, 1'b1);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // watchdog: the sequence needs well under 2000 cycles
   initial begin
      #50000;
      errors++;
      results();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      errors = 0;
      cmp_count = 0;
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      pat_en = 1'b0;
      gain_en = 1'b0;
      ofs_en = 1'b0;
      lv_in = 1'b0;
      c5_vin = 1'b0;
      c5_in = 14'h0000;
      ld_in = {14'h0abc, 14'h1234, 14'h0002, 14'h0001};
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      // table rows: write then read back, unmapped address reads 0
      foreach (ROWS[i]) begin
         reg_wr(ROWS[i].addr, ROWS[i].wdata);
         reg_rd(ROWS[i].addr, rv);
         chk(rv, ROWS[i].rexp);
      end
      chk(dig_sl, 4'ha);
      chk(line_sl, 4'h5);
      chk(ana_sl, 4'hc);
      chk(ofs_mis, 1'b1);
      reg_wr(`AOCR_OFS_COPY_OFS, 16'h0003);
      repeat (2) @(posedge ref_clk);
      #1 chk(ofs_mis, 1'b0);
      // reset in mid-run clears every register and the three sleep outputs
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({dig_sl, line_sl, ana_sl}, 12'h000);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int a = 8'h17; a <= 8'h1a; a++) begin
         reg_rd(a[7:0], rv);
         chk(rv, `AOCR_REG_RESET);
      end
      chk({dig_sl, line_sl, ana_sl}, 12'h000);
      // every pattern code on lines 3 and 4, flips of lines 3 and 4 set
      reg_wr(`AOCR_PWR_INV_OFS, 16'h000c);
      pat_en <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         reg_wr(`AOCR_PAT_SEL_OFS, 16'(c << 5) | 16'(c << 2));
         line_smp(PAT1[c]);
         chk(ld_out[55:42], (c == 0) ? 14'h3543 : 64'(PAT1[c]));
         line_smp(PAT2[c]);
         chk(ld_out[13:0], 14'h0001);
      end
      // enable low: pattern code ignored, inverted data on line 3
      reg_wr(`AOCR_PAT_SEL_OFS, 16'h0090);
      pat_en <= 1'b0;
      line_smp(14'h2dcb);
      chk(ld_out[55:42], 14'h3543);
      // line 3 asleep outputs 0, line 1 inverted
      reg_wr(`AOCR_PWR_INV_OFS, 16'h0401);
      line_smp(14'h0000);
      chk(ld_out[13:0], 14'h3ffe);
      // line 1 asleep outputs 0, line 3 plain data
      reg_wr(`AOCR_PWR_INV_OFS, 16'h0100);
      line_smp(14'h1234);
      chk(ld_out[13:0], 14'h0000);
      // ch5 offset -3, saturation, then gain of 1 dB
      reg_wr(`AOCR_GAIN_OFS_OFS, 16'h03fd);
      reg_wr(`AOCR_OFS_COPY_OFS, 16'h03fd);
      ch5_smp(14'd100, 14'd100);
      ofs_en <= 1'b1;
      ch5_smp(14'd100, 14'd97);
      reg_wr(`AOCR_GAIN_OFS_OFS, 16'h0005);
      reg_wr(`AOCR_OFS_COPY_OFS, 16'h0005);
      ch5_smp(14'h1fff, 14'h1fff);
      ch5_smp(14'h3ffe, 14'h0003);
      ofs_en <= 1'b0;
      reg_wr(`AOCR_GAIN_OFS_OFS, 16'h2800);
      reg_wr(`AOCR_OFS_COPY_OFS, 16'h0000);
      ch5_smp(14'd1000, 14'd1000);
      gain_en <= 1'b1;
      ch5_smp(14'd1000, 14'd1122);
      ch5_smp(14'h3c18, 14'h3b9d);
      results();
   end

endmodule // adc_output_ctrl_regs_tb_top
